// ### hrlp_top.sv
/*
  Reset combining, bus reset handling and link power sequencing of a hub.
  Assumes the board holds nrst_in low until supplies are in range and that
  all other inputs are synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module hrlp_top
  import hrlp_pkg::*;
#(
  parameter int unsigned SUSP_ENTRY_CYCLES = SUSP_ENTRY_CYC,
  parameter int unsigned SUSP_EXIT_CYCLES  = SUSP_EXIT_CYC,
  parameter int unsigned POR_CYCLES        = POR_HOLD_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       por_n_in,
  input  wire logic       bus_reset_in,
  input  wire logic       sleep_req_in,
  input  wire logic       suspend_req_in,
  input  wire logic       resume_in,
  input  wire logic       set_addr_in,
  input  wire logic [6:0] addr_in,
  input  wire logic       set_config_in,
  input  wire logic [7:0] config_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [1:0] cmd_in,
  input  wire logic [7:0] cmd_data_in,
  output logic            core_rst_n_out,
  output logic            standby_out,
  output logic            phy_en_out,
  output logic            pair_oe_n_out,
  output logic            osc_en_out,
  output logic            pll_en_out,
  output logic            xact_abort_out,
  output logic [1:0]      link_state_out,
  output logic            link_busy_out,
  output logic [6:0]      dev_addr_out,
  output logic [7:0]      dev_config_out,
  output logic            configured_out,
  output logic            dn_reset_out,
  output logic            spi_en_out,
  output logic            spi_go_out,
  output logic [7:0]      spi_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset merge: asynchronous assertion, two-stage synchronous release.
  logic         rst_comb_n;
  logic         rst_s1;
  logic         rst_s2;
  logic [CNT_W-1:0] por_cnt;
  logic         por_done;

  assign rst_comb_n = nrst_in & por_n_in;

  always_ff @(posedge clk_in or negedge rst_comb_n) begin
    if (!rst_comb_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // The power-on timer keeps the core in reset for a fixed interval.
  always_ff @(posedge clk_in or negedge rst_comb_n) begin
    if (!rst_comb_n) begin
      por_cnt  <= '0;
      por_done <= 1'b0;
    end else if (rst_s2 && !por_done) begin
      por_cnt  <= por_cnt + 1'b1;
      por_done <= (por_cnt == CNT_W'(POR_CYCLES - 1));
    end
  end

  wire core_rst_n = por_done;
  assign core_rst_n_out = core_rst_n;
  // Clocks stop during external reset; the oscillator must be up for the timer to run.
  assign standby_out    = ~nrst_in;
  assign osc_en_out     = nrst_in;
  assign pll_en_out     = nrst_in & rst_s2;
  assign xact_abort_out = ~core_rst_n;
  assign phy_en_out     = core_rst_n;
  assign pair_oe_n_out  = ~core_rst_n;
  // The upstream bus reset has no path to the downstream ports.
  assign dn_reset_out   = ~core_rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // Address and configuration; besides these two only the link sequencer sees the bus reset.
  always_ff @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      dev_addr_out   <= ADDR_DEFAULT;
      dev_config_out <= CONFIG_NONE;
    end else begin
      if (bus_reset_in)
        dev_addr_out <= ADDR_DEFAULT;
      else if (set_addr_in)
        dev_addr_out <= addr_in;
      if (bus_reset_in)
        dev_config_out <= CONFIG_NONE;
      else if (set_config_in)
        dev_config_out <= config_in;
    end
  end
  assign configured_out = (dev_config_out != CONFIG_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Serial pass-through commands; bus reset does not touch them.
  wire cmd_en   = cmd_valid_in && (cmd_in == CMD_SPI_EN);
  wire cmd_dis  = cmd_valid_in && (cmd_in == CMD_SPI_DIS);
  wire cmd_xfer = cmd_valid_in && (cmd_in == CMD_SPI_XFER) && spi_en_out;

  always_ff @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      spi_en_out   <= 1'b0;
      spi_go_out   <= 1'b0;
      spi_data_out <= 8'h00;
    end else begin
      if (cmd_en)
        spi_en_out <= 1'b1;
      else if (cmd_dis)
        spi_en_out <= 1'b0;
      spi_go_out <= cmd_xfer;
      if (cmd_xfer)
        spi_data_out <= cmd_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link power sequencer.
  hrlp_state_t      state;
  hrlp_state_t      next_state;
  logic [CNT_W-1:0] cnt;
  logic             cnt_clr;

  wire sleep_in_done  = (cnt == CNT_W'(SLEEP_ENTRY_CYC - 1));
  wire sleep_out_done = (cnt == CNT_W'(SLEEP_EXIT_CYC - 1));
  wire susp_in_done   = (cnt == CNT_W'(SUSP_ENTRY_CYCLES - 1));
  wire susp_out_done  = (cnt == CNT_W'(SUSP_EXIT_CYCLES - 1));

  always_comb begin
    next_state = state;
    cnt_clr    = 1'b1;
    unique case (state)
      HRLP_ON: begin
        if (suspend_req_in) next_state = HRLP_TO_L2;
        else if (sleep_req_in) next_state = HRLP_TO_L1;
      end
      HRLP_TO_L1: begin
        cnt_clr = sleep_in_done;
        if (sleep_in_done) next_state = HRLP_IN_L1;
      end
      HRLP_IN_L1: if (resume_in || bus_reset_in) next_state = HRLP_FROM_L1;
      HRLP_FROM_L1: begin
        cnt_clr = sleep_out_done;
        if (sleep_out_done) next_state = HRLP_ON;
      end
      HRLP_TO_L2: begin
        cnt_clr = susp_in_done;
        if (susp_in_done) next_state = HRLP_IN_L2;
      end
      HRLP_IN_L2: if (resume_in) next_state = HRLP_FROM_L2;
      HRLP_FROM_L2: begin
        cnt_clr = susp_out_done;
        if (susp_out_done) next_state = HRLP_ON;
      end
    endcase
    // A bus reset while suspended leaves suspend at once.
    if (bus_reset_in && (state == HRLP_IN_L2 || state == HRLP_FROM_L2)) begin
      next_state = HRLP_ON;
      cnt_clr    = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state <= HRLP_ON;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= cnt_clr ? '0 : cnt + 1'b1;
    end
  end

  assign link_state_out = (state == HRLP_IN_L1 || state == HRLP_FROM_L1) ? 2'(HRLP_L1) :
                          (state == HRLP_IN_L2 || state == HRLP_FROM_L2) ? 2'(HRLP_L2) : 2'(HRLP_L0);
  assign link_busy_out  = (state != HRLP_ON) && (state != HRLP_IN_L1) && (state != HRLP_IN_L2);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // The dwell state is entered one edge after the request and left
  // SLEEP_ENTRY_CYC edges later.
  localparam int SLEEP_IN_DLY = SLEEP_ENTRY_CYC;

  sequence s_sleep_entry;
    state == HRLP_ON && sleep_req_in && !suspend_req_in;
  endsequence

  a_sleep_entry_time: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    s_sleep_entry |=> (state == HRLP_TO_L1) ##SLEEP_IN_DLY state == HRLP_IN_L1)
    else $error("sleep entry time wrong");
  a_sleep_exit_on: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    state == HRLP_FROM_L1 && sleep_out_done |=> state == HRLP_ON && link_state_out == 2'(HRLP_L0))
    else $error("sleep exit not to on");
  a_addr_bus_rst: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    bus_reset_in |=> dev_addr_out == ADDR_DEFAULT)
    else $error("address not cleared by bus reset");
  a_config_bus_rst: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    bus_reset_in |=> !configured_out)
    else $error("configuration not cleared by bus reset");
  a_susp_wake: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    bus_reset_in && state == HRLP_IN_L2 |=> state == HRLP_ON)
    else $error("bus reset did not leave suspend");
  a_spi_keep: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    bus_reset_in && !cmd_valid_in |=> spi_en_out == $past(spi_en_out))
    else $error("bus reset changed pass-through state");
  a_spi_go_gate: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    spi_go_out |-> $past(spi_en_out) && spi_data_out == $past(cmd_data_in))
    else $error("transfer without enable");
  a_pair_hiz: assert property (@(posedge clk_in)
    !nrst_in |=> !phy_en_out && pair_oe_n_out && xact_abort_out)
    else $error("pairs driven during external reset");
  a_no_forward: assert property (@(posedge clk_in) disable iff (!core_rst_n)
    bus_reset_in |-> !dn_reset_out)
    else $error("bus reset forwarded downstream");

endmodule : hrlp_top
`default_nettype wire

// ### hrlp_pkg.sv
/*
  Constants and state types for the hub reset and link power block.
  Assumes a single 20 MHz core clock; all latencies are counted in its cycles.
*/
//
// Functional notes
// - Three link states on, sleep, suspend; every exit returns to on.
// - Sleep entry under 10 us, sleep exit under 50 us.
// - Suspend entry about 3 ms, on about 2 ms after resume starts.
// - Reset sources are power-on, external low pin and upstream bus reset.
// - Power-on holds internal reset from an internal timer for fixed time.
// - While external reset held, device stays in minimal-current standby.
// - External reset disables transceivers, differential pairs go high impedance.
// - External reset aborts all transactions at once, saving nothing.
// - External reset returns every internal register to default.
// - External reset stops oscillator and PLL until released.
// - Upstream bus reset sets device address to zero.
// - Upstream bus reset clears configuration to unconfigured.
// - Bus reset during suspend moves device to active.
// - Upstream bus reset is never forwarded to downstream ports.
// - Management accepts serial pass-through enable, write/read and disable commands.
package hrlp_pkg;
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned SLEEP_ENTRY_NS    = 10_000;
  localparam int unsigned SLEEP_EXIT_NS     = 50_000;
  localparam int unsigned SUSP_ENTRY_US     = 3_000;
  localparam int unsigned SUSP_EXIT_US      = 2_000;
  localparam int unsigned POR_HOLD_US       = 1_000;
  // Longest times round down, then lose one cycle; nothing clamps them at one cycle.
  localparam int unsigned SLEEP_ENTRY_CYC   = (SLEEP_ENTRY_NS * (CLK_HZ / 1_000_000)) / 1_000 - 1;
  localparam int unsigned SLEEP_EXIT_CYC    = (SLEEP_EXIT_NS * (CLK_HZ / 1_000_000)) / 1_000 - 1;
  localparam int unsigned SUSP_ENTRY_CYC    = SUSP_ENTRY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SUSP_EXIT_CYC     = SUSP_EXIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POR_HOLD_CYC      = POR_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W             = 17;
  localparam logic [6:0]  ADDR_DEFAULT      = 7'h00;
  localparam logic [7:0]  CONFIG_NONE       = 8'h00;
  localparam logic [1:0]  CMD_SPI_EN        = 2'h1;
  localparam logic [1:0]  CMD_SPI_XFER      = 2'h2;
  localparam logic [1:0]  CMD_SPI_DIS       = 2'h3;

  typedef enum logic [1:0] {HRLP_L0, HRLP_L1, HRLP_L2} hrlp_link_t;
  typedef enum logic [2:0] {HRLP_ON, HRLP_TO_L1, HRLP_IN_L1, HRLP_FROM_L1,
                            HRLP_TO_L2, HRLP_IN_L2, HRLP_FROM_L2} hrlp_state_t;
endpackage : hrlp_pkg

// ### hrlp_host.sv
/* Upstream host model: bus reset, resume signalling and management commands.
   Assumes the hub samples these on the rising edge of clk_in. */
`timescale 1ns/1ps
`default_nettype none
module hrlp_host (
  input  wire logic       clk_in,
  output var  logic       bus_reset_out,
  output var  logic       resume_out,
  output var  logic       cmd_valid_out,
  output var  logic [1:0] cmd_out,
  output var  logic [7:0] cmd_data_out
);
  initial begin
    bus_reset_out = 1'b0;
    resume_out    = 1'b0;
    cmd_valid_out = 1'b0;
    cmd_out       = 2'h0;
    cmd_data_out  = 8'h00;
  end
  // Data is inverted once released so a stale value can never pass as fresh.
  task automatic cmd(input logic [1:0] c, input logic [7:0] d);
    @(posedge clk_in);
    #5;
    cmd_valid_out = 1'b1;
    cmd_out       = c;
    cmd_data_out  = d;
    @(posedge clk_in);
    #5;
    cmd_valid_out = 1'b0;
    cmd_data_out  = ~d;
  endtask : cmd
  task automatic pulse(input bit is_reset);
    @(posedge clk_in);
    #5;
    if (is_reset) bus_reset_out = 1'b1;
    else resume_out = 1'b1;
    @(posedge clk_in);
    #5;
    bus_reset_out = 1'b0;
    resume_out    = 1'b0;
  endtask : pulse
endmodule : hrlp_host
`default_nettype wire

// ### tb.sv
/* Self-checking bench for the hub reset and link power block.
   Assumes short suspend and power-on counts set through parameters. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hrlp_pkg::*;
  localparam int SE = 20;
  localparam int SX = 10;
  localparam int PC = 8;
  logic clk_in, nrst_in, por_n_in, sleep_req, susp_req, set_addr, set_cfg, bus_reset, resume, cmd_valid;
  logic [6:0] addr;
  logic [7:0] cfg, cmd_data;
  logic [1:0] cmd;
  wire logic core_n, standby, phy_en, oe_n, osc_en, pll_en, abort_o, busy, cfgd, dn_rst, spi_en, spi_go;
  wire logic [1:0] link;
  wire logic [6:0] dev_addr;
  wire logic [7:0] dev_cfg, spi_data;
  int n_errors = 0;
  int tests_run = 0;
  int n;
  hrlp_top #(.SUSP_ENTRY_CYCLES(SE), .SUSP_EXIT_CYCLES(SX), .POR_CYCLES(PC)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .por_n_in(por_n_in), .bus_reset_in(bus_reset),
    .sleep_req_in(sleep_req), .suspend_req_in(susp_req), .resume_in(resume), .set_addr_in(set_addr),
    .addr_in(addr), .set_config_in(set_cfg), .config_in(cfg), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .cmd_data_in(cmd_data), .core_rst_n_out(core_n), .standby_out(standby), .phy_en_out(phy_en),
    .pair_oe_n_out(oe_n), .osc_en_out(osc_en), .pll_en_out(pll_en), .xact_abort_out(abort_o),
    .link_state_out(link), .link_busy_out(busy), .dev_addr_out(dev_addr), .dev_config_out(dev_cfg),
    .configured_out(cfgd), .dn_reset_out(dn_rst), .spi_en_out(spi_en), .spi_go_out(spi_go),
    .spi_data_out(spi_data));
  hrlp_host u_host (.clk_in(clk_in), .bus_reset_out(bus_reset), .resume_out(resume),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .cmd_data_out(cmd_data));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("FAIL %0t latency %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask : chk_rng
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #5;
  endtask : cyc
  task automatic wait_link(input logic [1:0] exp, input int lim);
    n = 0;
    while (link !== exp && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_link
  task automatic chk_rst(input logic r);
    chk(standby, r);
    chk(osc_en, !r);
    chk(pll_en, !r);
    chk(phy_en, !r);
    chk(oe_n, r);
    chk(abort_o, r);
    chk(core_n, !r);
    chk(dn_rst, r);
  endtask : chk_rst
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_release;
    chk_rst(1'b1);
    chk(dev_addr, ADDR_DEFAULT);
    nrst_in  = 1'b1;
    por_n_in = 1'b1;
    n = 0;
    while (core_n !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk_rng(n, PC + 2, PC + 2);
    chk_rst(1'b0);
  endtask : t_release
  task automatic t_bus_reset;
    set_addr = 1'b1;
    set_cfg  = 1'b1;
    addr     = 7'h55;
    cfg      = 8'h03;
    cyc(1);
    set_addr = 1'b0;
    set_cfg  = 1'b0;
    chk(cfgd, 1'b1);
    chk(dev_addr, 7'h55);
    u_host.cmd(CMD_SPI_EN, 8'h00);
    u_host.pulse(1'b1);
    chk(dev_addr, 8'h00);
    chk(dev_cfg, CONFIG_NONE);
    chk(cfgd, 1'b0);
    chk(spi_en, 1'b1);
    chk(dn_rst, 1'b0);
  endtask : t_bus_reset
  task automatic t_spi;
    u_host.cmd(CMD_SPI_DIS, 8'h00);
    chk(spi_en, 1'b0);
    u_host.cmd(CMD_SPI_XFER, 8'hA5);
    chk(spi_go, 1'b0);
    chk(spi_data, 8'h00);
    u_host.cmd(CMD_SPI_EN, 8'h00);
    u_host.cmd(CMD_SPI_XFER, 8'h3C);
    chk(spi_go, 1'b1);
    chk(spi_data, 8'h3C);
    cyc(1);
    chk(spi_go, 1'b0);
  endtask : t_spi
  task automatic t_link;
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    chk(busy, 1'b1);
    wait_link(2'h1, 400);
    chk_rng(n, 0, 199);
    chk(busy, 1'b0);
    u_host.pulse(1'b0);
    wait_link(2'h0, 1200);
    chk_rng(n, 0, 999);
    // Both requests at once: suspend has priority.
    sleep_req = 1'b1;
    susp_req  = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    susp_req  = 1'b0;
    wait_link(2'h2, 100);
    chk_rng(n, SE - 1, SE + 1);
    u_host.pulse(1'b0);
    wait_link(2'h0, 100);
    chk_rng(n, SX - 1, SX + 1);
    susp_req = 1'b1;
    cyc(1);
    susp_req = 1'b0;
    wait_link(2'h2, 100);
    chk(link, 2'h2);
    u_host.pulse(1'b1);
    chk(link, 2'h0);
  endtask : t_link
  task automatic t_mid_reset;
    set_addr  = 1'b1;
    addr      = 7'h2A;
    sleep_req = 1'b1;
    cyc(1);
    set_addr  = 1'b0;
    sleep_req = 1'b0;
    chk(dev_addr, 7'h2A);
    chk(busy, 1'b1);
    nrst_in = 1'b0;
    cyc(3);
    chk(spi_en, 1'b0);
    chk(busy, 1'b0);
    t_release();
  endtask : t_mid_reset
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst_in, por_n_in, sleep_req, susp_req, set_addr, set_cfg} = 6'h00;
    addr = 7'h00;
    cfg  = 8'h00;
    cyc(3);
    t_release();
    t_bus_reset();
    t_spi();
    t_link();
    t_mid_reset();
    results();
  end
  initial begin
    repeat (6000) @(posedge clk_in);
    n_errors++;
    results();
  end
endmodule : tb
`default_nettype wire
